// ---- rtl/dsm_detector_meters.sv ----
// detector scrambler, lock sequencer, sync detector and meters
// assumes sym_valid_in is one pulse per symbol, inputs synchronous to clk_sys_in
// Functional notes
// R1: one 23-bit LFSR, scrambler or descrambler
// R2: feedback tap chosen by office or remote
// R3: descrambler input from detector; -3=0, +3=1
// R4: four-level gives sign then magnitude bit
// R5: one step per symbol, two in four-level
// R6: locked scrambler runs with input forced ones
// R7: lock request bit starts hardware sequence
// R8: 23 descrambler bits, 127 scrambler bits, repeat
// R9: on sync raise interrupt, stay scrambling
// R10: sequence persists until software clears request
// R11: count matches over 128 comparisons
// R12: lock only when count exceeds threshold
// R13: error meter counts ones or agreements
// R14: meters run over interval, results then loaded
// R15: error counter saturates, copied at interval end
// R16: inner symbol counter clears, counts, saturates
// R17: top eight bits go to result
// R18: 32-bit error sum, upper half to result
// R19: count samples with error above threshold
// R20: alarm sum on own timer, compare threshold
// R21: mask bits gate interrupt sources onto output
// R22: alarm status refuses clear while alarm holds
// R23: slicer error is 16 bits wide
// R24: all meter results update on one strobe
// R25: clearing request aborts, setting restarts sequence
`timescale 1ns/1ps
`default_nettype none

module dsm_detector_meters
  import dsm_pkg::*;
#(
  parameter int TAP_CO = 5,
  parameter int TAP_RT = 18
)
(
  // clock and reset
  input  wire logic          clk_sys_in,
  input  wire logic          rst_n_in,
  // detector datapath
  input  wire logic          sym_valid_in,
  input  wire dsm_sym_s      sym_in,
  input  wire logic [15:0]   slicer_err_in,
  // host port
  input  wire dsm_host_req_s host_in,
  output logic [7:0]         host_rdata_out,
  // status
  output logic               locked_out,
  output logic               irq_oe_n_out
);

  typedef struct packed {
    dsm_lock_e   lk;
    logic [22:0] lfsr;
    logic [7:0]  bit_cnt;
    logic [7:0]  match_cnt;
    logic [7:0]  modes;
    logic [7:0]  mask;
    logic        irq_sync;
    logic        irq_snr;
    logic        snr_act;
    logic [15:0] mtr_int;
    logic [15:0] nth;
    logic [7:0]  lock_th;
    logic [15:0] snr_th;
    logic [15:0] snr_tmr;
    logic [15:0] mtr_cnt;
    logic [15:0] snr_cnt;
    logic [15:0] ber_cnt;
    logic [15:0] sym_cnt;
    logic [31:0] nsum;
    logic [15:0] nhist;
    logic [31:0] snr_sum;
    logic [15:0] ber_res;
    logic [7:0]  sym_res;
    logic [15:0] nsum_res;
    logic [15:0] nhist_res;
    logic [7:0]  hi_hold;
    logic [7:0]  rdata;
    logic        irq_oe_n;
    logic        locked;
  } dsm_state_s;

  dsm_state_s  st_q;
  dsm_state_s  st_d;
  logic        mtr_end;
  logic        snr_end;
  logic [15:0] ber_new;
  logic [15:0] sym_new;
  logic [31:0] nsum_new;
  logic [7:0]  match_new;
  logic        sync_set;

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic inc);
    sat_inc = (inc && v != DSM_SAT16) ? 16'(v + 16'h0001) : v;
  endfunction

  function automatic logic [15:0] abs16(input logic [15:0] e);
    abs16 = e[15] ? 16'(~e + 16'h0001) : e;
  endfunction

  function automatic logic [15:0] next_tmr(input logic [15:0] cnt, input logic [15:0] len);
    next_tmr = (cnt <= 16'h0001) ? len : 16'(cnt - 16'h0001);
  endfunction

  always_comb
  begin
    logic        four;
    logic        bitv;
    logic        fb;
    logic        dout;
    logic        eq;
    logic        descr;
    logic [15:0] aerr;
    int          tap;
    st_d      = st_q;
    four      = 1'b0;
    bitv      = 1'b0;
    fb        = 1'b0;
    dout      = 1'b0;
    eq        = 1'b0;
    descr     = 1'b0;
    aerr      = abs16(slicer_err_in); // R23
    tap       = 0;
    mtr_end   = 1'b0;
    snr_end   = 1'b0;
    sync_set  = 1'b0;
    ber_new   = st_q.ber_cnt;
    sym_new   = st_q.sym_cnt;
    nsum_new  = st_q.nsum;
    match_new = st_q.match_cnt;
    st_d.rdata = DSM_RST_BYTE;

    // host writes
    if (host_in.wr)
    begin
      case (host_in.addr)
        DSM_ADDR_MASK_HI:  st_d.mask = host_in.wdata;
        DSM_ADDR_DET_MODE: st_d.modes = host_in.wdata;
        DSM_ADDR_MTR_LO:   st_d.mtr_int[7:0] = host_in.wdata;
        DSM_ADDR_MTR_HI:   st_d.mtr_int[15:8] = host_in.wdata;
        DSM_ADDR_NTH_LO:   st_d.nth[7:0] = host_in.wdata;
        DSM_ADDR_NTH_HI:   st_d.nth[15:8] = host_in.wdata;
        DSM_ADDR_LOCK_TH:  st_d.lock_th = host_in.wdata;
        DSM_ADDR_SNR_LO:   st_d.snr_th[7:0] = host_in.wdata;
        DSM_ADDR_SNR_HI:   st_d.snr_th[15:8] = host_in.wdata;
        DSM_ADDR_STMR_LO:  st_d.snr_tmr[7:0] = host_in.wdata;
        DSM_ADDR_STMR_HI:  st_d.snr_tmr[15:8] = host_in.wdata;
        DSM_ADDR_IRQ_SRC:
        begin
          if (host_in.wdata[DSM_IRQ_SYNC_BIT])
            st_d.irq_sync = 1'b0;
          if (host_in.wdata[DSM_IRQ_SNR_BIT] && !st_q.snr_act) // R22
            st_d.irq_snr = 1'b0;
        end
        default: ;
      endcase
    end

    // sequencer start and abort
    if (!st_d.modes[DSM_MODE_LOCK_BIT]) // R10 R25
    begin
      st_d.lk      = LK_IDLE;
      st_d.bit_cnt = DSM_RST_BYTE;
    end
    else if (st_d.lk == LK_IDLE) // R7 R25
    begin
      st_d.lk        = LK_DESCR;
      st_d.bit_cnt   = DSM_RST_BYTE;
      st_d.match_cnt = DSM_RST_BYTE;
    end

    if (sym_valid_in)
    begin
      four = st_d.modes[DSM_MODE_FOUR_BIT];
      tap  = st_d.modes[DSM_MODE_RT_BIT] ? TAP_RT : TAP_CO; // R2
      for (int k = 0; k < 2; k++)
      begin
        if (k == 0 || four) // R5
        begin
          bitv  = (k == 0) ? sym_in.sign : sym_in.mag; // R3 R4
          fb    = st_d.lfsr[tap - 1] ^ st_d.lfsr[DSM_LFSR_LEN - 1]; // R1
          descr = (st_d.lk == LK_IDLE) || (st_d.lk == LK_DESCR);
          eq    = ((~fb) == bitv);
          if (descr)
          begin
            dout      = bitv ^ fb;
            st_d.lfsr = {st_d.lfsr[21:0], bitv};
            ber_new   = sat_inc(ber_new, dout); // R13 R15
          end
          else
          begin
            dout      = ~fb; // R6
            st_d.lfsr = {st_d.lfsr[21:0], dout};
            ber_new   = sat_inc(ber_new, eq); // R13 R15
          end
          unique case (st_d.lk)
            LK_IDLE, LK_LOCKED: ;
            LK_DESCR:
            begin
              st_d.bit_cnt = 8'(st_d.bit_cnt + 8'h01);
              if (st_d.bit_cnt == DSM_DESCR_BITS) // R8
              begin
                st_d.lk        = LK_SCRAM;
                st_d.bit_cnt   = DSM_RST_BYTE;
                st_d.match_cnt = {7'h00, eq}; // R11
              end
            end
            LK_SCRAM:
            begin
              st_d.match_cnt = 8'(st_d.match_cnt + {7'h00, eq}); // R11
              st_d.bit_cnt   = 8'(st_d.bit_cnt + 8'h01);
              if (st_d.bit_cnt == DSM_SCRAM_BITS) // R8
              begin
                match_new    = st_d.match_cnt;
                st_d.bit_cnt = DSM_RST_BYTE;
                if (st_d.match_cnt > st_q.lock_th) // R12
                begin
                  st_d.lk  = LK_LOCKED; // R9
                  sync_set = 1'b1;
                end
                else
                  st_d.lk = LK_DESCR; // R8
              end
            end
          endcase
        end
      end

      // interval meters
      sym_new  = sat_inc(st_q.sym_cnt, sym_in.mag); // R16
      nsum_new = st_q.nsum + {16'h0000, aerr}; // R18
      st_d.nhist = sat_inc(st_q.nhist, aerr > st_q.nth); // R19
      mtr_end  = (st_q.mtr_cnt <= 16'h0001); // R14 R24
      st_d.mtr_cnt = next_tmr(st_q.mtr_cnt, st_q.mtr_int);
      if (mtr_end)
      begin
        st_d.ber_res   = ber_new; // R15 R24
        st_d.sym_res   = sym_new[15:8]; // R17
        st_d.nsum_res  = nsum_new[31:16]; // R18
        st_d.nhist_res = st_d.nhist; // R19
        st_d.ber_cnt   = DSM_RST_WORD;
        st_d.sym_cnt   = DSM_RST_WORD; // R16
        st_d.nsum      = {DSM_RST_WORD, DSM_RST_WORD};
        st_d.nhist     = DSM_RST_WORD;
      end
      else
      begin
        st_d.ber_cnt = ber_new;
        st_d.sym_cnt = sym_new;
        st_d.nsum    = nsum_new;
      end

      // alarm meter on its own timer
      st_d.snr_sum = st_q.snr_sum + {16'h0000, aerr}; // R20
      snr_end      = (st_q.snr_cnt <= 16'h0001);
      st_d.snr_cnt = next_tmr(st_q.snr_cnt, st_q.snr_tmr);
      if (snr_end)
      begin
        st_d.snr_act = (st_d.snr_sum[31:16] > st_q.snr_th); // R20
        st_d.snr_sum = {DSM_RST_WORD, DSM_RST_WORD};
      end
    end

    // status sets win over clears
    if (sync_set)
      st_d.irq_sync = 1'b1; // R9 R12
    if (st_d.snr_act && snr_end)
      st_d.irq_snr = 1'b1; // R20

    // host reads, result low byte latches high byte
    if (host_in.rd)
    begin
      case (host_in.addr)
        DSM_ADDR_MASK_HI:  st_d.rdata = st_q.mask;
        DSM_ADDR_DET_MODE: st_d.rdata = st_q.modes;
        DSM_ADDR_IRQ_SRC:
        begin
          st_d.rdata = DSM_RST_BYTE;
          st_d.rdata[DSM_IRQ_SYNC_BIT] = st_q.irq_sync;
          st_d.rdata[DSM_IRQ_SNR_BIT]  = st_q.irq_snr;
        end
        DSM_ADDR_MTR_LO:   st_d.rdata = st_q.mtr_int[7:0];
        DSM_ADDR_MTR_HI:   st_d.rdata = st_q.mtr_int[15:8];
        DSM_ADDR_NTH_LO:   st_d.rdata = st_q.nth[7:0];
        DSM_ADDR_NTH_HI:   st_d.rdata = st_q.nth[15:8];
        DSM_ADDR_LOCK_TH:  st_d.rdata = st_q.lock_th;
        DSM_ADDR_SNR_LO:   st_d.rdata = st_q.snr_th[7:0];
        DSM_ADDR_SNR_HI:   st_d.rdata = st_q.snr_th[15:8];
        DSM_ADDR_STMR_LO:  st_d.rdata = st_q.snr_tmr[7:0];
        DSM_ADDR_STMR_HI:  st_d.rdata = st_q.snr_tmr[15:8];
        DSM_ADDR_SYM:      st_d.rdata = st_q.sym_res;
        DSM_ADDR_BER_LO:
        begin
          st_d.rdata   = st_q.ber_res[7:0];
          st_d.hi_hold = st_q.ber_res[15:8];
        end
        DSM_ADDR_NSUM_LO:
        begin
          st_d.rdata   = st_q.nsum_res[7:0];
          st_d.hi_hold = st_q.nsum_res[15:8];
        end
        DSM_ADDR_NHST_LO:
        begin
          st_d.rdata   = st_q.nhist_res[7:0];
          st_d.hi_hold = st_q.nhist_res[15:8];
        end
        DSM_ADDR_BER_HI, DSM_ADDR_NSUM_HI, DSM_ADDR_NHST_HI:
          st_d.rdata = st_q.hi_hold;
        default:           st_d.rdata = DSM_RST_BYTE;
      endcase
    end

    // shared interrupt, low while any unmasked cause
    st_d.irq_oe_n = ~((st_d.irq_sync & ~st_d.mask[DSM_IRQ_SYNC_BIT])
                    | (st_d.irq_snr & ~st_d.mask[DSM_IRQ_SNR_BIT])); // R21
    st_d.locked   = (st_d.lk == LK_LOCKED); // R9
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      st_q          <= '0;
      st_q.lk       <= LK_IDLE;
      st_q.mask     <= DSM_RST_MASK;
      st_q.irq_oe_n <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign host_rdata_out = st_q.rdata;
  assign locked_out     = st_q.locked;
  assign irq_oe_n_out   = st_q.irq_oe_n;

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_meter_end;
    sym_valid_in && mtr_end;
  endsequence
  property p_abort;
    st_q.lk != LK_IDLE |-> st_q.modes[DSM_MODE_LOCK_BIT];
  endproperty
  a_abort: assert property (p_abort) else $error("sequencer active without request"); // R25

  property p_lock_above;
    (st_q.lk == LK_SCRAM && st_d.lk == LK_LOCKED) |-> match_new > st_q.lock_th ##1 st_q.irq_sync;
  endproperty
  a_lock_above: assert property (p_lock_above) else $error("lock without threshold or flag"); // R12

  property p_retry;
    (st_q.lk == LK_SCRAM && st_d.lk == LK_DESCR) |-> match_new <= st_q.lock_th;
  endproperty
  a_retry: assert property (p_retry) else $error("retry despite sufficient matches"); // R8

  property p_descr_len;
    st_q.lk == LK_DESCR |-> st_q.bit_cnt < DSM_DESCR_BITS;
  endproperty
  a_descr_len: assert property (p_descr_len) else $error("descrambler step too long"); // R8

  property p_scram_len;
    st_q.lk == LK_SCRAM |-> st_q.bit_cnt < DSM_SCRAM_BITS && st_q.match_cnt <= DSM_SYNC_WIN;
  endproperty
  a_scram_len: assert property (p_scram_len) else $error("scrambler step too long"); // R8

  property p_locked_stays;
    (st_q.lk == LK_LOCKED && st_d.modes[DSM_MODE_LOCK_BIT]) |=> st_q.lk == LK_LOCKED;
  endproperty
  a_locked_stays: assert property (p_locked_stays) else $error("left lock while requested"); // R9

  property p_ber_sat;
    (st_q.ber_cnt == DSM_SAT16 && !(sym_valid_in && mtr_end)) |=> st_q.ber_cnt == DSM_SAT16;
  endproperty
  a_ber_sat: assert property (p_ber_sat) else $error("error counter wrapped"); // R15

  property p_results;
    s_meter_end |=> st_q.ber_res == $past(ber_new) && st_q.sym_res == $past(sym_new[15:8])
                    && st_q.nsum_res == $past(nsum_new[31:16]) && st_q.sym_cnt == DSM_RST_WORD;
  endproperty
  a_results: assert property (p_results) else $error("meter results not loaded together"); // R24

  property p_snr_hold;
    (st_q.irq_snr && st_q.snr_act) |=> st_q.irq_snr;
  endproperty
  a_snr_hold: assert property (p_snr_hold) else $error("alarm status cleared while active"); // R22

  property p_irq_gate;
    st_q.irq_oe_n == !((st_q.irq_sync && !st_q.mask[DSM_IRQ_SYNC_BIT])
                       || (st_q.irq_snr && !st_q.mask[DSM_IRQ_SNR_BIT]));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt output disagrees with mask"); // R21

endmodule

`default_nettype wire

// ---- rtl/dsm_pkg.sv ----
// package for the detector scrambler and meters block
// assumes an 8-bit host register port and a symbol-rate strobe
package dsm_pkg;

  // host port register offsets
  localparam logic [7:0] DSM_ADDR_MASK_HI  = 8'h03;
  localparam logic [7:0] DSM_ADDR_IRQ_SRC  = 8'h05;
  localparam logic [7:0] DSM_ADDR_DET_MODE = 8'h0c;
  localparam logic [7:0] DSM_ADDR_MTR_LO   = 8'h18;
  localparam logic [7:0] DSM_ADDR_MTR_HI   = 8'h19;
  localparam logic [7:0] DSM_ADDR_NTH_LO   = 8'h2a;
  localparam logic [7:0] DSM_ADDR_NTH_HI   = 8'h2b;
  localparam logic [7:0] DSM_ADDR_LOCK_TH  = 8'h2e;
  localparam logic [7:0] DSM_ADDR_SNR_LO   = 8'h34;
  localparam logic [7:0] DSM_ADDR_SNR_HI   = 8'h35;
  localparam logic [7:0] DSM_ADDR_STMR_LO  = 8'h36;
  localparam logic [7:0] DSM_ADDR_STMR_HI  = 8'h37;
  localparam logic [7:0] DSM_ADDR_BER_LO   = 8'h4c;
  localparam logic [7:0] DSM_ADDR_BER_HI   = 8'h4d;
  localparam logic [7:0] DSM_ADDR_SYM      = 8'h4e;
  localparam logic [7:0] DSM_ADDR_NSUM_LO  = 8'h50;
  localparam logic [7:0] DSM_ADDR_NSUM_HI  = 8'h51;
  localparam logic [7:0] DSM_ADDR_NHST_LO  = 8'h52;
  localparam logic [7:0] DSM_ADDR_NHST_HI  = 8'h53;

  // field positions
  localparam int DSM_MODE_LOCK_BIT = 0;
  localparam int DSM_MODE_FOUR_BIT = 1;
  localparam int DSM_MODE_RT_BIT   = 2;
  localparam int DSM_IRQ_SNR_BIT   = 0;
  localparam int DSM_IRQ_SYNC_BIT  = 3;

  // reset values
  localparam logic [7:0]  DSM_RST_BYTE = 8'h00;
  localparam logic [7:0]  DSM_RST_MASK = 8'hff;
  localparam logic [15:0] DSM_RST_WORD = 16'h0000;

  // locking sequence counts
  localparam int          DSM_LFSR_LEN    = 23;
  localparam logic [7:0]  DSM_DESCR_BITS  = 8'h17;
  localparam logic [7:0]  DSM_SCRAM_BITS  = 8'h7f;
  localparam logic [7:0]  DSM_SYNC_WIN    = 8'h80;
  localparam logic [15:0] DSM_SAT16       = 16'hffff;

  typedef enum logic [1:0] {LK_IDLE, LK_DESCR, LK_SCRAM, LK_LOCKED} dsm_lock_e;

  // detected symbol: sign first, magnitude second
  typedef struct packed {
    logic sign;
    logic mag;
  } dsm_sym_s;

  // one host port access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsm_host_req_s;

endpackage

// ---- verification/dsm_det_model.sv ----
// detector model: symbol stream and slicer error into the block
// assumes bench controls change just after a clock edge
`timescale 1ns/1ps
`default_nettype none

module dsm_det_model
  import dsm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // bench control
  input  wire logic        en_in,
  input  wire logic        scram_in,
  input  wire logic        four_in,
  input  wire logic [4:0]  tap_in,
  input  wire logic [2:0]  gap_in,
  input  wire dsm_sym_s    sym_in,
  input  wire logic [15:0] err_in,
  // detector outputs
  output logic             sym_valid_out,
  output dsm_sym_s         sym_out,
  output logic [15:0]      err_out,
  output int               sent_out
);
  logic [22:0] hist_q;
  logic [2:0]  wait_q;
  logic        b0;
  logic        b1;

  // far end sends scrambled ones
  always_comb
  begin
    b0 = ~(hist_q[tap_in - 5'd1] ^ hist_q[22]);
    b1 = ~(hist_q[tap_in - 5'd2] ^ hist_q[21]);
  end

  always_ff @(posedge clk_sys_in)
  begin
    sym_valid_out <= 1'b0;
    if (!rst_n_in)
    begin
      hist_q   <= 23'h5a5a5a;
      wait_q   <= 3'h0;
      sent_out <= 0;
      sym_out  <= 2'h0;
      err_out  <= 16'h0;
    end
    else if (en_in && wait_q == 3'h0)
    begin
      sym_valid_out <= 1'b1;
      sent_out      <= sent_out + 1;
      wait_q        <= gap_in - 3'h1;
      err_out       <= err_in;
      sym_out       <= sym_in;
      if (scram_in && four_in)
      begin
        sym_out <= {b0, b1};
        hist_q  <= {hist_q[20:0], b0, b1};
      end
      else if (scram_in)
      begin
        sym_out <= {b0, 1'b0};
        hist_q  <= {hist_q[21:0], b0};
      end
    end
    else
    begin
      // idle lines keep toggling
      wait_q  <= (wait_q == 3'h0) ? 3'h0 : wait_q - 3'h1;
      sym_out <= ~sym_out;
      err_out <= ~err_out;
    end
  end
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the detector scrambler and meters block
// assumes the detector model drives the symbol path
`timescale 1ns/1ps
`default_nettype none

module testbench
  import dsm_pkg::*;
;
  localparam int IVAL = 600;
  localparam int TCO = 5;
  localparam int TRT = 18;

  logic          clk_sys_in = 1'b0;
  logic          rst_n_in;
  logic          sym_valid;
  dsm_sym_s      sym;
  logic [15:0]   err;
  dsm_host_req_s host;
  logic [7:0]    rdata;
  logic          locked;
  logic          irq_oe_n;
  logic          en;
  logic          scram;
  logic          four;
  logic [4:0]    tap;
  logic [2:0]    gap;
  logic          fast;
  dsm_sym_s      msym;
  logic [15:0]   merr;
  logic [15:0]   thr;
  int            sent;
  int            fail_count = 0;
  int            comparisons = 0;
  int            seed = 8;

  always #10 clk_sys_in = ~clk_sys_in;

  dsm_detector_meters #(.TAP_CO(TCO), .TAP_RT(TRT)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sym_valid_in(sym_valid),
    .sym_in(sym), .slicer_err_in(err), .host_in(host), .host_rdata_out(rdata),
    .locked_out(locked), .irq_oe_n_out(irq_oe_n));

  dsm_det_model det (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .en_in(en), .scram_in(scram),
    .four_in(four), .tap_in(tap), .gap_in(gap), .sym_in(msym), .err_in(merr),
    .sym_valid_out(sym_valid), .sym_out(sym), .err_out(err), .sent_out(sent));

  task automatic complete_run;
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    host.wr = 1'b1;
    host.addr = a;
    host.wdata = d;
    @(posedge clk_sys_in);
    #1;
    host.wr = 1'b0;
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic host_rd(input logic [7:0] a, output logic [7:0] d);
    host.rd = 1'b1;
    host.addr = a;
    @(posedge clk_sys_in);
    #1;
    d = rdata;
    host.rd = 1'b0;
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    host_rd(a, d);
    chk(nm, {8'h0, e}, {8'h0, d});
  endtask

  task automatic chk_rd16(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [7:0] lo;
    logic [7:0] hi;
    host_rd(a, lo);
    host_rd(a + 8'h01, hi);
    chk(nm, e, {hi, lo});
  endtask

  task automatic send(input int n);
    int start;
    int k;
    start = sent;
    k = 0;
    gap = fast ? 3'h1 : 3'(2 + ($unsigned($random(seed)) % 3));
    en = 1'b1;
    while (sent - start < n && k < n * 8)
    begin
      @(posedge clk_sys_in);
      #1;
      k++;
    end
    en = 1'b0;
    if (sent - start < n)
    begin
      fail_count++;
      complete_run();
    end
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask

  function automatic logic [7:0] mode_byte(input logic lk, input logic fl, input logic rt);
    logic [7:0] m;
    m = 8'h00;
    m[DSM_MODE_LOCK_BIT] = lk;
    m[DSM_MODE_FOUR_BIT] = fl;
    m[DSM_MODE_RT_BIT] = rt;
    return m;
  endfunction

  function automatic logic [15:0] sum_hi(input logic [15:0] mag);
    logic [31:0] s;
    s = 32'(IVAL) * {16'h0, mag};
    return s[31:16];
  endfunction

  task automatic check_meters(input logic inner, input logic [15:0] mag);
    chk_rd(DSM_ADDR_SYM, inner ? 8'(IVAL >> 8) : 8'h00, "sym_hist");
    chk_rd16(DSM_ADDR_NSUM_LO, sum_hi(mag), "noise_sum");
    chk_rd16(DSM_ADDR_NHST_LO, (mag > thr) ? 16'(IVAL) : 16'h0, "noise_hist");
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    host = '0;
    en = 1'b0;
    scram = 1'b0;
    four = 1'b0;
    tap = 5'(TCO);
    gap = 3'h2;
    fast = 1'b0;
    msym = 2'h0;
    merr = 16'h0;
    thr = 16'h0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'b1;
    chk_rd(DSM_ADDR_MASK_HI, DSM_RST_MASK, "mask_reset");
    chk_rd(DSM_ADDR_IRQ_SRC, DSM_RST_BYTE, "irq_src_reset");
    chk_rd(8'h7f, 8'h00, "unmapped");
    host_wr(DSM_ADDR_BER_LO, 8'h5a);
    chk_rd(DSM_ADDR_BER_LO, DSM_RST_BYTE, "ber_read_only");
    host_wr(DSM_ADDR_MTR_LO, 8'h58);
    host_wr(DSM_ADDR_MTR_HI, 8'h02);
    chk_rd16(DSM_ADDR_MTR_LO, 16'(IVAL), "interval");
    host_wr(DSM_ADDR_LOCK_TH, 8'h80);
    chk_rd(DSM_ADDR_LOCK_TH, 8'h80, "lock_th");
    scram = 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      four = (c == 2);
      tap = (c == 1) ? 5'(TRT) : 5'(TCO);
      host_wr(DSM_ADDR_DET_MODE, 8'h00);
      host_wr(DSM_ADDR_IRQ_SRC, 8'h09);
      host_wr(DSM_ADDR_MASK_HI, 8'hf7);
      host_wr(DSM_ADDR_DET_MODE, mode_byte(1'b1, four, c == 1));
      if (c == 0)
      begin
        send(400);
        chk("no_lock", 16'h0, {15'h0, locked});
        chk_rd(DSM_ADDR_IRQ_SRC, 8'h00, "sync_bit_held");
        host_wr(DSM_ADDR_LOCK_TH, 8'h7f);
      end
      send(400);
      chk("lock", 16'h1, {15'h0, locked});
      chk_rd(DSM_ADDR_IRQ_SRC, 8'h08, "sync_bit");
      chk("irq_sync", 16'h0, {15'h0, irq_oe_n});
      send(2 * IVAL + 2);
      chk("still_locked", 16'h1, {15'h0, locked});
      chk_rd16(DSM_ADDR_BER_LO, four ? 16'(2 * IVAL) : 16'(IVAL), "ber");
      host_wr(DSM_ADDR_MASK_HI, DSM_RST_MASK);
      chk("irq_masked", 16'h1, {15'h0, irq_oe_n});
      host_wr(DSM_ADDR_DET_MODE, mode_byte(1'b0, four, c == 1));
      chk("abort", 16'h0, {15'h0, locked});
      send(2 * IVAL + 2);
      chk_rd16(DSM_ADDR_BER_LO, four ? 16'(2 * IVAL) : 16'(IVAL), "ber_descr");
    end
    scram = 1'b0;
    host_wr(DSM_ADDR_DET_MODE, 8'h00);
    host_wr(DSM_ADDR_IRQ_SRC, 8'h09);
    thr = 16'h2000 + 16'($unsigned($random(seed)) % 4096);
    host_wr(DSM_ADDR_NTH_LO, thr[7:0]);
    host_wr(DSM_ADDR_NTH_HI, thr[15:8]);
    host_wr(DSM_ADDR_STMR_LO, 8'h10);
    host_wr(DSM_ADDR_SNR_LO, 8'h01);
    msym = ($random(seed) & 1) ? 2'b11 : 2'b01;
    merr = thr + 16'h1;
    send(2 * IVAL + 2);
    check_meters(1'b1, thr + 16'h1);
    chk_rd(DSM_ADDR_IRQ_SRC, 8'h01, "snr_bit");
    chk("snr_masked", 16'h1, {15'h0, irq_oe_n});
    host_wr(DSM_ADDR_MASK_HI, 8'hfe);
    chk("irq_snr", 16'h0, {15'h0, irq_oe_n});
    host_wr(DSM_ADDR_IRQ_SRC, 8'h01);
    chk_rd(DSM_ADDR_IRQ_SRC, 8'h01, "snr_clear_refused");
    msym = ($random(seed) & 1) ? 2'b10 : 2'b00;
    merr = 16'h0 - thr;
    send(2 * IVAL + 2);
    check_meters(1'b0, thr);
    merr = 16'h0;
    send(40);
    host_wr(DSM_ADDR_IRQ_SRC, 8'h01);
    chk_rd(DSM_ADDR_IRQ_SRC, 8'h00, "snr_cleared");
    chk("irq_released", 16'h1, {15'h0, irq_oe_n});
    scram = 1'b1;
    four = 1'b1;
    host_wr(DSM_ADDR_DET_MODE, mode_byte(1'b0, 1'b1, 1'b0));
    send(12);
    host_wr(DSM_ADDR_MTR_LO, 8'h02);
    host_wr(DSM_ADDR_MTR_HI, 8'h80);
    fast = 1'b1;
    send(33400);
    chk_rd16(DSM_ADDR_BER_LO, DSM_SAT16, "ber_saturated");
    complete_run();
  end
endmodule

`default_nettype wire
